/* File: p3i_port3.sv */
/*
  Port 3 pin configuration, pull-up control and edge interrupt logic,
  with the port 2 pull-up enables, as a classic Wishbone slave.
  Assumes one clock, synchronous active-high reset, and external pads
  that resolve the output enables and pull-up controls.
*/
`timescale 1ns/1ns
`default_nettype none
`include "p3i_regs.svh"

module p3i_port3
  import p3i_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [9:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic [`P3I_P3_BITS_W-1:0]    p3_pin_i,
  input  wire logic [`P3I_P3_BITS_W-1:0]    p3_data_i,
  output logic      [`P3I_P3_BITS_W-1:0]    p3_pin_o,
  output logic      [`P3I_P3_BITS_W-1:0]    p3_pin_oe_n_o,
  output logic      [`P3I_P3_BITS_W-1:0]    p3_pullup_en_o,
  output logic      [`P3I_P2_PULLUP_W-1:0]  p2_pullup_en_o,
  output logic                              irq_o
);

  p3i_state_t s_q;
  p3i_state_t s_d;

  logic [7:0] idx;
  logic       req;
  logic       wr;
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr  = req && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [`P3I_P3_BITS_W-1:0] edge_hit;
    logic [`P3I_P3_BITS_W-1:0] clr;
    logic [1:0]                mode;
    edge_hit = '0;
    clr      = '0;
    mode     = 2'h0;
    s_d      = s_q;

    // Three-stage sampling; a change counts when stages two and three agree
    s_d.sync1 = p3_pin_i;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < `P3I_P3_BITS_W; i++)
    begin
      if (s_q.sync2[i] == s_q.sync3[i])
      begin
        s_d.level[i] = s_q.sync3[i];
        if (s_q.sync3[i] != s_q.level[i])
        begin
          edge_hit[i] = s_q.p3_edge[i] ? s_q.sync3[i] : !s_q.sync3[i];
        end
      end
    end

    // Register writes; only the low implemented bits are stored
    if (wr)
    begin
      case (idx)
        `P3I_IDX_P2_PULLUP: s_d.p2_pullup = wb_dat_i[`P3I_P2_PULLUP_W-1:0];
        `P3I_IDX_P3_CONFIG: s_d.p3_config = wb_dat_i[`P3I_P3_CONFIG_W-1:0];
        `P3I_IDX_P3_IRQ_EN: s_d.p3_irq_en = wb_dat_i[`P3I_P3_BITS_W-1:0];
        `P3I_IDX_P3_PULLUP: s_d.p3_pullup = wb_dat_i[`P3I_P3_BITS_W-1:0];
        `P3I_IDX_P3_EDGE:   s_d.p3_edge   = wb_dat_i[`P3I_P3_BITS_W-1:0];
        `P3I_IDX_IRQ_STATUS: clr          = wb_dat_i[`P3I_P3_BITS_W-1:0];
        `P3I_IDX_IRQ_MASK:  s_d.irq_mask  = wb_dat_i[`P3I_P3_BITS_W-1:0];
        default: ;
      endcase
    end

    // enable gates capture; set beats clear
    s_d.irq_status = (s_q.irq_status & ~clr) | (edge_hit & s_q.p3_irq_en);

    for (int i = 0; i < `P3I_P3_BITS_W; i++)
    begin
      mode = s_q.p3_config[2*i +: 2];
      case (mode)
        `P3I_MODE_PUSHPULL:
        begin
          s_d.p3_out[i]  = p3_data_i[i];
          s_d.p3_oe_n[i] = 1'b0;
        end
        `P3I_MODE_OPENDRAIN:
        begin
          // Drives low only; high is released to the pull-up
          s_d.p3_out[i]  = 1'b0;
          s_d.p3_oe_n[i] = p3_data_i[i];
        end
        default:
        begin
          s_d.p3_out[i]  = 1'b0;
          s_d.p3_oe_n[i] = 1'b1;
        end
      endcase
    end
    s_d.p3_pull = s_q.p3_pullup;
    s_d.p2_pull = s_q.p2_pullup;
    s_d.irq     = |(s_d.irq_status & s_d.irq_mask);

    // One-cycle ack; unmapped indices read zero and writes are ignored
    s_d.ack   = req;
    s_d.rdata = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      case (idx)
        `P3I_IDX_P2_PULLUP:  s_d.rdata[`P3I_P2_PULLUP_W-1:0] = s_q.p2_pullup;
        `P3I_IDX_P3_CONFIG:  s_d.rdata[`P3I_P3_CONFIG_W-1:0] = s_q.p3_config;
        `P3I_IDX_P3_IRQ_EN:  s_d.rdata[`P3I_P3_BITS_W-1:0]   = s_q.p3_irq_en;
        `P3I_IDX_P3_PULLUP:  s_d.rdata[`P3I_P3_BITS_W-1:0]   = s_q.p3_pullup;
        `P3I_IDX_P3_EDGE:    s_d.rdata[`P3I_P3_BITS_W-1:0]   = s_q.p3_edge;
        `P3I_IDX_IRQ_STATUS: s_d.rdata[`P3I_P3_BITS_W-1:0]   = s_q.irq_status;
        `P3I_IDX_IRQ_MASK:   s_d.rdata[`P3I_P3_BITS_W-1:0]   = s_q.irq_mask;
        `P3I_IDX_PIN_LEVEL:  s_d.rdata[`P3I_P3_BITS_W-1:0]   = s_q.level;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q           <= '0;
      s_q.p3_oe_n   <= 2'h3;
      s_q.p2_pullup <= `P3I_RST_P2_PULLUP;
      s_q.p3_config <= `P3I_RST_P3_CONFIG;
      s_q.p3_irq_en <= `P3I_RST_P3_BITS;
      s_q.p3_pullup <= `P3I_RST_P3_BITS;
      s_q.p3_edge   <= `P3I_RST_P3_BITS;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o       = s_q.rdata;
  assign wb_ack_o       = s_q.ack;
  assign p3_pin_o       = s_q.p3_out;
  assign p3_pin_oe_n_o  = s_q.p3_oe_n;
  assign p3_pullup_en_o = s_q.p3_pull;
  assign p2_pullup_en_o = s_q.p2_pull;
  assign irq_o          = s_q.irq;

endmodule
`default_nettype wire

/* File: p3i_regs.svh */
/*
  Register offsets, field positions and reset values of the port 2/3
  pin configuration and external interrupt block.
  Assumes a classic Wishbone slave with 32-bit data, one register per word.
*/
`ifndef P3I_REGS_SVH
`define P3I_REGS_SVH

// Printed register indices; byte address is four times the index
`define P3I_IDX_P2_PULLUP   8'hF4
`define P3I_IDX_P3_CONFIG   8'hF5
`define P3I_IDX_P3_IRQ_EN   8'hF6
`define P3I_IDX_P3_PULLUP   8'hF7
`define P3I_IDX_P3_EDGE     8'hF8
`define P3I_IDX_IRQ_STATUS  8'hF9
`define P3I_IDX_IRQ_MASK    8'hFA
`define P3I_IDX_PIN_LEVEL   8'hFB

// Implemented field widths
`define P3I_P2_PULLUP_W     4
`define P3I_P3_CONFIG_W     4
`define P3I_P3_BITS_W       2

// Reset values
`define P3I_RST_P2_PULLUP   4'h0
`define P3I_RST_P3_CONFIG   4'h0
`define P3I_RST_P3_BITS     2'h0

// Pin mode codes
`define P3I_MODE_INPUT      2'h0
`define P3I_MODE_PUSHPULL   2'h1
`define P3I_MODE_OPENDRAIN  2'h2
`define P3I_MODE_NONE       2'h3

`endif

/* File: p3i_pkg.sv */
/*
  Types of the port 2/3 pin configuration and external interrupt block.
  Assumes p3i_regs.svh supplies the field widths.
*/
`include "p3i_regs.svh"

package p3i_pkg;

  typedef struct packed {
    logic [`P3I_P2_PULLUP_W-1:0] p2_pullup;
    logic [`P3I_P3_CONFIG_W-1:0] p3_config;
    logic [`P3I_P3_BITS_W-1:0]   p3_irq_en;
    logic [`P3I_P3_BITS_W-1:0]   p3_pullup;
    logic [`P3I_P3_BITS_W-1:0]   p3_edge;
    logic [`P3I_P3_BITS_W-1:0]   irq_status;
    logic [`P3I_P3_BITS_W-1:0]   irq_mask;
    logic [`P3I_P3_BITS_W-1:0]   sync1;
    logic [`P3I_P3_BITS_W-1:0]   sync2;
    logic [`P3I_P3_BITS_W-1:0]   sync3;
    logic [`P3I_P3_BITS_W-1:0]   level;
    logic [`P3I_P3_BITS_W-1:0]   p3_out;
    logic [`P3I_P3_BITS_W-1:0]   p3_oe_n;
    logic [`P3I_P3_BITS_W-1:0]   p3_pull;
    logic [`P3I_P2_PULLUP_W-1:0] p2_pull;
    logic                        irq;
    logic                        ack;
    logic [31:0]                 rdata;
  } p3i_state_t;

endpackage

/* File: p3i_port3_sva.sv */
/* Port checker of the port 3 block.
   Assumes a bind onto p3i_port3. */
`timescale 1ns/1ns
`default_nettype none
module p3i_port3_sva (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i, p2_pullup_en_o,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [1:0]  p3_data_i, p3_pin_o, p3_pin_oe_n_o, p3_pullup_en_o
);
  logic tk, wr;
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = tk & wb_we_i & wb_sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (tk |=> wb_ack_o) else $error("no ack");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data");
  chk_reset_out: assert property ($fell(rst_i) |->
    {p2_pullup_en_o, p3_pullup_en_o, p3_pin_oe_n_o, irq_o} == 9'h006) else $error("reset");
  chk_p3_pull: assert property (wr && wb_adr_i[9:2] == 8'hF7 |=> ##1
    p3_pullup_en_o == $past(wb_dat_i[1:0], 2)) else $error("p3 pull");
  chk_p2_pull: assert property (wr && wb_adr_i[9:2] == 8'hF4 |=> ##1
    p2_pullup_en_o == $past(wb_dat_i[3:0], 2)) else $error("p2 pull");
  chk_sel_gate: assert property (tk && wb_we_i && !wb_sel_i[0] |=> ##1
    $stable(p2_pullup_en_o)) else $error("sel");
  chk_drive_data: assert property (
    (~p3_pin_oe_n_o & (p3_pin_o ^ $past(p3_data_i))) == 2'h0) else $error("drive");
  cover property (wr);
  cover property ($rose(irq_o));
  cover property (p3_pin_oe_n_o == 2'h2);
endmodule
`default_nettype wire

/* File: p3i_pads.sv */
/* Pads and outside circuits of the two port 3 pins.
   Assumes the bench sets the outside drive. */
`timescale 1ns/1ns
`default_nettype none
module p3i_pads (
  input  wire logic       clk_i,
  input  wire logic [1:0] oe_n_i, out_i, pull_i, ext_en_i, ext_i,
  output logic      [1:0] lvl_o
);
  // Floating pins wander, never hold
  logic [1:0] flt_q = 2'h1;
  always_ff @(posedge clk_i) flt_q <= ~flt_q;
  always_comb
    for (int i = 0; i < 2; i++)
      lvl_o[i] = !oe_n_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] : pull_i[i] | flt_q[i];
endmodule
`default_nettype wire

/* File: p3i_port3_tb.sv */
/* Self-checking bench of the port 3 block.
   Assumes pads model and checker compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module p3i_port3_tb;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic [9:0]  adr = 10'h0;
  logic [3:0]  sel = 4'hF, p2u;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [1:0]  pdat = 2'h0, xen = 2'h0, xv = 2'h3, lvl, po, oen, pu;
  int          error_cnt = 0, num_checks = 0;
  // Index, write value, read value; pull-ups before enables
  logic [23:0] rows [7] = '{24'hF4FF0F, 24'hF5FF0F, 24'hF7FF03, 24'hF8FF03, 24'hF6FF03,
                           24'hFAFF03, 24'hF3FF00};
  always #25 clk_i = ~clk_i;
  p3i_port3 i_p3i_port3 (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .p3_pin_i(lvl), .p3_data_i(pdat), .p3_pin_o(po), .p3_pin_oe_n_o(oen),
    .p3_pullup_en_o(pu), .p2_pullup_en_o(p2u), .irq_o(irq));
  p3i_pads i_p3i_pads (.clk_i(clk_i), .oe_n_i(oen), .out_i(po), .pull_i(pu),
    .ext_en_i(xen), .ext_i(xv), .lvl_o(lvl));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pin(input logic [1:0] v);
    xv <= v;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #300000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[k])
    begin
      wb(1'b0, rows[k][23:16], 32'h0);
      chk("reset value", 32'h0, rd);
      wb(1'b1, rows[k][23:16], rows[k][15:8]);
      wb(1'b0, rows[k][23:16], 32'h0);
      chk("readback", rows[k][7:0], rd);
    end
    chk("pads", 32'hFF, {p2u, pu, oen});
    sel <= 4'hE;
    wb(1'b1, 8'hF4, 32'h0);
    sel <= 4'hF;
    wb(1'b1, 8'hF8, 32'h1);
    wb(1'b1, 8'hF9, 32'h3);
    xen <= 2'h3;
    pin(2'h0);
    wb(1'b0, 8'hF9, 32'h0);
    chk("fall status", 32'h2, rd);
    chk("irq", 32'h1, irq);
    wb(1'b1, 8'hFA, 32'h1);
    wb(1'b0, 8'hF4, 32'h0);
    chk("masked irq", 32'h0, irq);
    chk("sel ignore", 32'hF, rd);
    wb(1'b1, 8'hF9, 32'h2);
    wb(1'b1, 8'hFA, 32'h3);
    pin(2'h1);
    wb(1'b0, 8'hF9, 32'h0);
    chk("rise status", 32'h1, rd);
    wb(1'b0, 8'hFB, 32'h0);
    chk("pin level", 32'h1, rd);
    wb(1'b1, 8'hF9, 32'h1);
    wb(1'b1, 8'hF6, 32'h1);
    pin(2'h3);
    pin(2'h1);
    wb(1'b0, 8'hF9, 32'h0);
    chk("blocked status", 32'h0, rd);
    chk("idle irq", 32'h0, irq);
    xen <= 2'h0;
    pdat <= 2'h2;
    wb(1'b1, 8'hF5, 32'h9);
    chk("od release", 32'h4, {oen, po[0]});
    pdat <= 2'h1;
    repeat (2) @(posedge clk_i);
    chk("drive", 32'h1, {oen, po});
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset pads", 32'h6, {p2u, pu, oen, irq});
    give_verdict();
  end
endmodule
bind p3i_port3 p3i_port3_sva i_p3i_port3_sva (.*);
`default_nettype wire
